/* verilog/ftp_pkg.sv */
/*
 * Package for the flexible threshold protection block: register map,
 * field positions, reset values and timing constants.
 * Assumes a 20 MHz pclk and an APB register bus with 32-bit data.
 */
`default_nettype none

package ftp_pkg;

    // ========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ           = 20000000;
    localparam int unsigned TICK_US          = 1000;
    localparam int unsigned TICK_CYCLES      = CLK_HZ / 1000000 * TICK_US;
    localparam int unsigned TIMER_W          = 16;
    localparam int unsigned DATA_W           = 16;

    // ========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS          = 8'h00;
    localparam logic [7:0] LIMIT_OFS         = 8'h04;
    localparam logic [7:0] RATIO_OFS         = 8'h08;
    localparam logic [7:0] PICKUP_DLY_OFS    = 8'h0c;
    localparam logic [7:0] DROPOUT_DLY_OFS   = 8'h10;
    localparam logic [7:0] TRIP_DLY_OFS      = 8'h14;
    localparam logic [7:0] MIN_TRIP_OFS      = 8'h18;
    localparam logic [7:0] STATE_OFS         = 8'h1c;
    localparam logic [7:0] IRQ_STAT_OFS      = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFS      = 8'h24;
    localparam logic [7:0] VALUE_OFS         = 8'h28;

    // ========================================================
    // Control register fields
    localparam int unsigned CTRL_ENABLE      = 0;
    localparam int unsigned CTRL_UNDER       = 1;
    localparam int unsigned CTRL_COMBINED    = 2;
    localparam int unsigned CTRL_VBLK_EN     = 3;
    localparam int unsigned CTRL_IBLK_EN     = 4;
    localparam int unsigned CTRL_BF_EN       = 5;
    localparam int unsigned CTRL_SRC_LSB     = 8;
    localparam int unsigned CTRL_W           = 11;

    // Source selection
    localparam logic [2:0] SRC_PHASE         = 3'h0;
    localparam logic [2:0] SRC_POS_SEQ       = 3'h1;
    localparam logic [2:0] SRC_POWER        = 3'h2;
    localparam logic [2:0] SRC_VOLTAGE       = 3'h3;

    // Ratio is 8.8 fixed point; 1.0 = 0x100
    localparam logic [15:0] RATIO_ONE        = 16'h0100;
    localparam logic [15:0] RATIO_RST        = 16'h00f0;

    // Interrupt bits
    localparam int unsigned IRQ_PICKUP       = 0;
    localparam int unsigned IRQ_TRIP         = 1;
    localparam int unsigned IRQ_BLOCK        = 2;
    localparam int unsigned IRQ_W            = 3;

    // Reset values
    localparam logic [CTRL_W-1:0]  CTRL_RST  = 11'h000;
    localparam logic [15:0]        LIMIT_RST = 16'hffff;
    localparam logic [15:0]        DLY_RST   = 16'h0000;

endpackage

`default_nettype wire

/* verilog/ftp_core.sv */
/*
 * Flexible threshold protection: derives a monitored quantity from
 * three currents and three voltages, compares it against a limit with
 * hysteresis, and runs pickup, dropout, trip and minimum trip timers.
 * Assumes measured samples arrive synchronous to pclk; the block, VT failure,
 * fuse failure and wire break inputs are asynchronous and are synchronised here.
 */
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module ftp_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] i_a,
    input  wire logic [15:0] i_b,
    input  wire logic [15:0] i_c,
    input  wire logic [15:0] v_a,
    input  wire logic [15:0] v_b,
    input  wire logic [15:0] v_c,
    input  wire logic        range_ok,
    input  wire logic        internal_fault,
    input  wire logic        block_in,
    input  wire logic        feeder_vt_failure_input,
    input  wire logic        fuse_failure,
    input  wire logic        wire_break,
    input  wire logic        bf_assign_match,
    output logic      [2:0]  pickup_out,
    output logic      [2:0]  trip_out,
    output logic             bf_start,
    output logic             irq
);

    // ========================================================
    // Input synchronisers
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic       ext_block;
    logic       vt_fail;
    logic       fuse_fail;
    logic       wbreak;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {wire_break, fuse_failure,
                          feeder_vt_failure_input, block_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign ext_block = sync2_reg[0];
    assign vt_fail   = sync2_reg[1];
    assign fuse_fail = sync2_reg[2];
    assign wbreak    = sync2_reg[3];

    // ========================================================
    // Registers
    logic [ftp_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [15:0] limit_reg, limit_next;
    logic [15:0] ratio_reg, ratio_next;
    logic [15:0] pu_dly_reg, pu_dly_next;
    logic [15:0] do_dly_reg, do_dly_next;
    logic [15:0] tr_dly_reg, tr_dly_next;
    logic [15:0] min_tr_reg, min_tr_next;
    logic [ftp_pkg::IRQ_W-1:0] stat_reg, stat_next;
    logic [ftp_pkg::IRQ_W-1:0] mask_reg, mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    logic [ftp_pkg::IRQ_W-1:0] events;
    logic        blocked;
    logic [2:0]  pickup_w;
    logic [2:0]  trip_w;
    localparam int unsigned DATA_W_L = ftp_pkg::DATA_W;
    logic [DATA_W_L-1:0] quantity;

    wire logic wr = psel && penable && pwrite && pready_reg;
    wire logic rd_setup = psel && !penable;
    wire logic under = ctrl_reg[ftp_pkg::CTRL_UNDER];
    wire logic [2:0] src = ctrl_reg[ftp_pkg::CTRL_SRC_LSB +: 3];

    always_comb begin
        ctrl_next    = ctrl_reg;
        limit_next   = limit_reg;
        ratio_next   = ratio_reg;
        pu_dly_next  = pu_dly_reg;
        do_dly_next  = do_dly_reg;
        tr_dly_next  = tr_dly_reg;
        min_tr_next  = min_tr_reg;
        mask_next    = mask_reg;
        stat_next    = stat_reg;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        pready_next  = rd_setup;
        if (wr) begin
            unique case (paddr)
                ftp_pkg::CTRL_OFS:        ctrl_next = pwdata[ftp_pkg::CTRL_W-1:0];
                ftp_pkg::LIMIT_OFS:       limit_next = pwdata[15:0];
                ftp_pkg::RATIO_OFS: begin
                    // Illegal ratio for the current mode is refused
                    if (under ? (pwdata[15:0] > ftp_pkg::RATIO_ONE)
                              : (pwdata[15:0] < ftp_pkg::RATIO_ONE)) begin
                        ratio_next = pwdata[15:0];
                    end
                end
                ftp_pkg::PICKUP_DLY_OFS:  pu_dly_next = pwdata[15:0];
                ftp_pkg::DROPOUT_DLY_OFS: do_dly_next = pwdata[15:0];
                ftp_pkg::TRIP_DLY_OFS:    tr_dly_next = pwdata[15:0];
                ftp_pkg::MIN_TRIP_OFS:    min_tr_next = pwdata[15:0];
                ftp_pkg::IRQ_STAT_OFS:    stat_next = stat_reg & ~pwdata[ftp_pkg::IRQ_W-1:0];
                ftp_pkg::IRQ_MASK_OFS:    mask_next = pwdata[ftp_pkg::IRQ_W-1:0];
                default:                  pslverr_next = 1'b0;
            endcase
        end
        // Set wins over clear
        stat_next = stat_next | events;
        if (rd_setup) begin
            unique case (paddr)
                ftp_pkg::CTRL_OFS:        prdata_next = {21'h0, ctrl_reg};
                ftp_pkg::LIMIT_OFS:       prdata_next = {16'h0, limit_reg};
                ftp_pkg::RATIO_OFS:       prdata_next = {16'h0, ratio_reg};
                ftp_pkg::PICKUP_DLY_OFS:  prdata_next = {16'h0, pu_dly_reg};
                ftp_pkg::DROPOUT_DLY_OFS: prdata_next = {16'h0, do_dly_reg};
                ftp_pkg::TRIP_DLY_OFS:    prdata_next = {16'h0, tr_dly_reg};
                ftp_pkg::MIN_TRIP_OFS:    prdata_next = {16'h0, min_tr_reg};
                ftp_pkg::STATE_OFS:       prdata_next = {25'h0, blocked, trip_w, pickup_w};
                ftp_pkg::IRQ_STAT_OFS:    prdata_next = {29'h0, stat_reg};
                ftp_pkg::IRQ_MASK_OFS:    prdata_next = {29'h0, mask_reg};
                ftp_pkg::VALUE_OFS:       prdata_next = {16'h0, quantity};
                default: begin
                    prdata_next  = 32'h0000_0000;
                    pslverr_next = !pwrite;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= ftp_pkg::CTRL_RST;
            limit_reg   <= ftp_pkg::LIMIT_RST;
            ratio_reg   <= ftp_pkg::RATIO_RST;
            pu_dly_reg  <= ftp_pkg::DLY_RST;
            do_dly_reg  <= ftp_pkg::DLY_RST;
            tr_dly_reg  <= ftp_pkg::DLY_RST;
            min_tr_reg  <= ftp_pkg::DLY_RST;
            stat_reg    <= 3'h0;
            mask_reg    <= 3'h0;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            limit_reg   <= limit_next;
            ratio_reg   <= ratio_next;
            pu_dly_reg  <= pu_dly_next;
            do_dly_reg  <= do_dly_next;
            tr_dly_reg  <= tr_dly_next;
            min_tr_reg  <= min_tr_next;
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next && psel;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ========================================================
    // Derived quantity
    // Positive sequence approximated by the mean magnitude; phase
    // angles are not carried on this interface.
    logic [17:0] sum3;
    logic [33:0] psum;
    always_comb begin
        sum3 = {2'b00, i_a} + {2'b00, i_b} + {2'b00, i_c};
        psum = {2'b00, {16'h0000, i_a} * {16'h0000, v_a}}
             + {2'b00, {16'h0000, i_b} * {16'h0000, v_b}}
             + {2'b00, {16'h0000, i_c} * {16'h0000, v_c}};
        unique case (src)
            ftp_pkg::SRC_POS_SEQ: quantity = 16'(sum3 / 18'd3);
            ftp_pkg::SRC_POWER:   quantity = psum[33:18];
            ftp_pkg::SRC_VOLTAGE: quantity = v_a;
            default:              quantity = i_a;
        endcase
    end

    // ========================================================
    // Blocking
    wire logic uses_v = (src == ftp_pkg::SRC_POWER) || (src == ftp_pkg::SRC_VOLTAGE);
    wire logic uses_i = (src != ftp_pkg::SRC_VOLTAGE);
    assign blocked = ext_block
        || !range_ok || internal_fault
        || (ctrl_reg[ftp_pkg::CTRL_VBLK_EN] && uses_v && (vt_fail || fuse_fail))
        || (ctrl_reg[ftp_pkg::CTRL_IBLK_EN] && uses_i && wbreak)
        || !ctrl_reg[ftp_pkg::CTRL_ENABLE];

    // ========================================================
    // Timer limits in cycles
    // Each timer counts from the start of its own interval, so a delay
    // never ends early on the phase of a shared tick
    wire logic [31:0] pu_lim = 32'(pu_dly_reg) * ftp_pkg::TICK_CYCLES;
    wire logic [31:0] do_lim = 32'(do_dly_reg) * ftp_pkg::TICK_CYCLES;
    wire logic [31:0] tr_lim = 32'(tr_dly_reg) * ftp_pkg::TICK_CYCLES;
    wire logic [31:0] mt_lim = 32'(min_tr_reg) * ftp_pkg::TICK_CYCLES;

    // ========================================================
    // Per-phase (or single) pickup and trip channels
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_ch
            logic [15:0] val;
            logic [31:0] reset_lvl;
            logic        raw_reg, raw_next;
            logic        pu_reg, pu_next;
            logic        tr_reg, tr_next;
            logic [31:0] pu_cnt_reg, pu_cnt_next;
            logic [31:0] do_cnt_reg, do_cnt_next;
            logic [31:0] tr_cnt_reg, tr_cnt_next;
            logic [31:0] mt_cnt_reg, mt_cnt_next;
            logic        active;

            always_comb begin
                if (src == ftp_pkg::SRC_PHASE && ctrl_reg[ftp_pkg::CTRL_COMBINED])
                    val = (g == 0) ? i_a : (g == 1) ? i_b : i_c;
                else
                    val = quantity;
                active = (g == 0) || (src == ftp_pkg::SRC_PHASE
                         && ctrl_reg[ftp_pkg::CTRL_COMBINED]);
                reset_lvl = limit_reg * ratio_reg;
                // Hysteresis: leave only past limit * ratio
                if (raw_reg)
                    raw_next = under ? ({8'h00, val, 8'h00} < reset_lvl)
                                     : ({8'h00, val, 8'h00} > reset_lvl);
                else
                    raw_next = under ? (val < limit_reg)
                                     : (val > limit_reg);
                pu_next = pu_reg;
                pu_cnt_next = pu_cnt_reg;
                do_cnt_next = do_cnt_reg;
                if (raw_reg && !pu_reg) begin
                    if (pu_cnt_reg >= pu_lim) pu_next = 1'b1;
                    else pu_cnt_next = pu_cnt_reg + 32'h1;
                    do_cnt_next = 32'h0;
                end else if (raw_reg) begin
                    do_cnt_next = 32'h0;
                end else if (pu_reg) begin
                    // Dropout hold bridges short gaps
                    if (do_cnt_reg >= do_lim) pu_next = 1'b0;
                    else do_cnt_next = do_cnt_reg + 32'h1;
                    pu_cnt_next = 32'h0;
                end else begin
                    pu_cnt_next = 32'h0;
                end
                tr_next = tr_reg;
                tr_cnt_next = tr_cnt_reg;
                mt_cnt_next = mt_cnt_reg;
                if (pu_reg && !tr_reg) begin
                    if (tr_cnt_reg >= tr_lim) begin
                        tr_next = 1'b1;
                        mt_cnt_next = 32'h0;
                    end else tr_cnt_next = tr_cnt_reg + 32'h1;
                end else if (tr_reg) begin
                    if (mt_cnt_reg < mt_lim)
                        mt_cnt_next = mt_cnt_reg + 32'h1;
                    if (!pu_reg && mt_cnt_reg >= mt_lim) begin
                        tr_next = 1'b0;
                        tr_cnt_next = 32'h0;
                    end
                end else begin
                    tr_cnt_next = 32'h0;
                end
                if (blocked || !active) begin
                    raw_next = 1'b0;
                    pu_next = 1'b0;
                    tr_next = 1'b0;
                    pu_cnt_next = 32'h0;
                    do_cnt_next = 32'h0;
                    tr_cnt_next = 32'h0;
                    mt_cnt_next = 32'h0;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    raw_reg    <= 1'b0;
                    pu_reg     <= 1'b0;
                    tr_reg     <= 1'b0;
                    pu_cnt_reg <= 32'h0;
                    do_cnt_reg <= 32'h0;
                    tr_cnt_reg <= 32'h0;
                    mt_cnt_reg <= 32'h0;
                end else begin
                    raw_reg    <= raw_next;
                    pu_reg     <= pu_next;
                    tr_reg     <= tr_next;
                    pu_cnt_reg <= pu_cnt_next;
                    do_cnt_reg <= do_cnt_next;
                    tr_cnt_reg <= tr_cnt_next;
                    mt_cnt_reg <= mt_cnt_next;
                end
            end

            assign pickup_w[g] = pu_reg;
            assign trip_w[g]   = tr_reg;
        end
    endgenerate

    // ========================================================
    // Outputs and interrupt
    logic [2:0] pu_q_reg;
    logic [2:0] tr_q_reg;
    logic       bf_reg, bf_next;
    logic       irq_reg, irq_next;
    logic       blk_q_reg;

    always_comb begin
        bf_next  = (|trip_w) && ctrl_reg[ftp_pkg::CTRL_BF_EN]
                   && bf_assign_match;
        irq_next = |(stat_reg & mask_reg);
        events = {blocked && !blk_q_reg,
                  |(trip_w & ~tr_q_reg),
                  |(pickup_w & ~pu_q_reg)};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_q_reg  <= 3'h0;
            tr_q_reg  <= 3'h0;
            bf_reg    <= 1'b0;
            irq_reg   <= 1'b0;
            // Disabled after reset counts as blocked: no false block event
            blk_q_reg <= 1'b1;
        end else begin
            pu_q_reg  <= pickup_w;
            tr_q_reg  <= trip_w;
            bf_reg    <= bf_next;
            irq_reg   <= irq_next;
            blk_q_reg <= blocked;
        end
    end

    assign pickup_out = pu_q_reg;
    assign trip_out   = tr_q_reg;
    assign bf_start   = bf_reg;
    assign irq        = irq_reg;

endmodule

`default_nettype wire

/* test/ftp_core_asserts.sv */
/* Checker for ftp_core: bus answer timing and protection outputs.
   Sees only the core's ports; bound to every ftp_core below. */
`timescale 1ns/100ps
`default_nettype none

module ftp_core_asserts (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       range_ok,
    input wire logic       internal_fault,
    input wire logic       block_in,
    input wire logic [2:0] pickup_out,
    input wire logic [2:0] trip_out,
    input wire logic       bf_start
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ========================================================
    // Bus answer
    sequence s_setup; psel && !penable; endsequence
    property p_ready_after_setup; s_setup |=> pready; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("pready missing after setup");
    property p_ready_single; pready |=> !pready; endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("pready longer than one cycle");
    property p_err_with_ready; pslverr |-> pready; endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("pslverr without pready");

    // ========================================================
    // Protection outputs
    // Eight cycles cover the two-flop synchroniser and output register
    sequence s_ext_block; block_in [*8]; endsequence
    property p_block_clears; s_ext_block |-> pickup_out == 3'h0; endproperty
    a_block_clears: assert property (p_block_clears)
        else $error("pickup during external block");
    property p_range_blocks;
        (!range_ok || internal_fault) [*4] |-> pickup_out == 3'h0;
    endproperty
    a_range_blocks: assert property (p_range_blocks)
        else $error("pickup during internal block");
    property p_trip_needs_pickup; $rose(trip_out[0]) |-> pickup_out[0];
    endproperty
    a_trip_needs_pickup: assert property (p_trip_needs_pickup)
        else $error("trip rose without pickup");
    property p_trip_holds; $fell(trip_out[0]) |-> !pickup_out[0]; endproperty
    a_trip_holds: assert property (p_trip_holds)
        else $error("trip fell while pickup held");
    property p_bf_follows_trip;
        $rose(bf_start) |-> trip_out != 3'h0 || $past(trip_out) != 3'h0;
    endproperty
    a_bf_follows_trip: assert property (p_bf_follows_trip)
        else $error("breaker failure start without trip");
endmodule

bind ftp_core ftp_core_asserts ftp_core_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .range_ok(range_ok),
    .internal_fault(internal_fault), .block_in(block_in),
    .pickup_out(pickup_out), .trip_out(trip_out), .bf_start(bf_start)
);

`default_nettype wire

/* test/ftp_xfmr_model.sv */
/* Instrument transformer and breaker model for ftp_core.
   Assumes levels from the bench; samples are synchronous to pclk. */
`timescale 1ns/100ps
`default_nettype none

module ftp_xfmr_model (
    input  wire logic        pclk,
    input  wire logic [47:0] lvl,
    input  wire logic [15:0] volt,
    input  wire logic [2:0]  trip_out,
    output logic      [15:0] i_a,
    output logic      [15:0] i_b,
    output logic      [15:0] i_c,
    output logic      [15:0] v_a,
    output logic      [15:0] v_b,
    output logic      [15:0] v_c,
    output var int           breaker_ops
);
    logic tripped = 1'b0;

    // ========================================================
    // Six channels and breaker
    initial begin
        {i_a, i_b, i_c, v_a, v_b, v_c} = '0;
        breaker_ops = 0;
    end
    always @(posedge pclk) begin
        {i_a, i_b, i_c} <= lvl;
        {v_a, v_b, v_c} <= {3{volt}};
        if (|trip_out && !tripped) begin
            breaker_ops <= breaker_ops + 1;
        end
        tripped <= |trip_out;
    end
endmodule

`default_nettype wire

/* test/ftp_core_tb_top.sv */
/* Bench for ftp_core: APB register access and protection scenarios.
   Assumes the transformer model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module ftp_core_tb_top;
    localparam int T = ftp_pkg::TICK_CYCLES;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdq;
    logic        pready, pslverr, serr, bf_start, irq;
    logic [15:0] i_a, i_b, i_c, v_a, v_b, v_c;
    logic [5:0]  ext = 6'h00;
    logic        bfm = 1'b1;
    logic [47:0] lvl = 48'h0;
    logic [2:0]  pickup_out, trip_out;
    int          breaker_ops, err_count = 0, n_checks = 0;

    always #25 pclk = ~pclk;

    ftp_xfmr_model ftp_xfmr_model_inst (.pclk(pclk), .lvl(lvl),
        .volt(16'h0400), .trip_out(trip_out), .i_a(i_a), .i_b(i_b),
        .i_c(i_c), .v_a(v_a), .v_b(v_b), .v_c(v_c),
        .breaker_ops(breaker_ops));
    ftp_core ftp_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_a(i_a), .i_b(i_b), .i_c(i_c), .v_a(v_a),
        .v_b(v_b), .v_c(v_c), .range_ok(!ext[4]),
        .internal_fault(ext[5]), .block_in(ext[0]),
        .feeder_vt_failure_input(ext[1]), .fuse_failure(ext[2]),
        .wire_break(ext[3]), .bf_assign_match(bfm),
        .pickup_out(pickup_out), .trip_out(trip_out),
        .bf_start(bf_start), .irq(irq));

    // ========================================================
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Ends one edge after release so the next setup never collides
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdq = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rdq)
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, e,
                       input string nm);
        wr(a, d);
        rdc(a, e, nm);
    endtask
    task automatic pt(input logic [2:0] p, input logic [2:0] t);
        `CHK("pickup", p, pickup_out)
        `CHK("trip", t, trip_out)
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run is a little over four ticks
    initial begin
        cyc(4 * T + T / 2);
        err_count++;
        wrap_up();
    end

    // ========================================================
    // Scenarios
    initial begin
        cyc(4);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(ftp_pkg::CTRL_OFS, 32'h0, "ctrl");
        rdc(ftp_pkg::LIMIT_OFS, 32'hffff, "limit");
        rdc(8'h40, 32'h0, "unmapped");
        `CHK("slverr", 1'b1, serr)
        wrc(ftp_pkg::RATIO_OFS, 32'h180, 32'hf0, "ratio");
        wrc(ftp_pkg::RATIO_OFS, 32'he0, 32'he0, "ratio");
        wr(ftp_pkg::LIMIT_OFS, 32'd100);
        wr(ftp_pkg::CTRL_OFS, 32'h21);
        lvl <= {16'd200, 32'h0};
        cyc(8);
        pt(3'h1, 3'h1);
        `CHK("bf", 1'b1, bf_start)
        `CHK("breaker", 1, breaker_ops)
        bfm <= 1'b0;
        cyc(2);
        `CHK("bf match", 1'b0, bf_start)
        bfm <= 1'b1;
        rdc(ftp_pkg::STATE_OFS, 32'h09, "state");
        apb(1'b0, ftp_pkg::IRQ_STAT_OFS, 32'h0);
        `CHK("irq stat", 32'h3, rdq)
        `CHK("irq masked", 1'b0, irq)
        wr(ftp_pkg::IRQ_MASK_OFS, 32'h2);
        cyc(2);
        `CHK("irq", 1'b1, irq)
        wr(ftp_pkg::IRQ_STAT_OFS, 32'h7);
        cyc(2);
        `CHK("irq clear", 1'b0, irq)
        lvl <= 48'h0;
        wr(ftp_pkg::PICKUP_DLY_OFS, 32'h1);
        wr(ftp_pkg::DROPOUT_DLY_OFS, 32'h1);
        wr(ftp_pkg::TRIP_DLY_OFS, 32'h1);
        lvl <= {16'd200, 32'h0};
        cyc(T / 2);
        pt(3'h0, 3'h0);
        cyc(T);
        pt(3'h1, 3'h0);
        lvl <= 48'h0;
        cyc(T * 3 / 4);
        pt(3'h1, 3'h1);
        cyc(T * 3 / 4);
        pt(3'h0, 3'h0);
        wr(ftp_pkg::PICKUP_DLY_OFS, 32'h0);
        wr(ftp_pkg::DROPOUT_DLY_OFS, 32'h0);
        wr(ftp_pkg::TRIP_DLY_OFS, 32'h0);
        wr(ftp_pkg::MIN_TRIP_OFS, 32'h1);
        lvl <= {16'd200, 32'h0};
        cyc(8);
        lvl <= 48'h0;
        cyc(8);
        pt(3'h0, 3'h1);
        cyc(T + T / 5);
        pt(3'h0, 3'h0);
        wr(ftp_pkg::MIN_TRIP_OFS, 32'h0);
        wr(ftp_pkg::LIMIT_OFS, 32'h4);
        wr(ftp_pkg::CTRL_OFS, 32'h219);
        lvl <= {16'd256, 16'd512, 16'd768};
        cyc(8);
        rdc(ftp_pkg::VALUE_OFS, 32'h6, "power");
        for (int k = 0; k < 6; k++) begin
            ext <= 6'h1 << k;
            cyc(8);
            `CHK("blocked", 3'h0, pickup_out)
            ext <= 6'h00;
            cyc(8);
            `CHK("released", 3'h1, pickup_out)
        end
        wr(ftp_pkg::CTRL_OFS, 32'h101);
        lvl <= {16'd30, 16'd60, 16'd90};
        cyc(8);
        rdc(ftp_pkg::VALUE_OFS, 32'd60, "posseq");
        wr(ftp_pkg::LIMIT_OFS, 32'd100);
        wr(ftp_pkg::CTRL_OFS, 32'h3);
        wrc(ftp_pkg::RATIO_OFS, 32'h80, 32'he0, "ratio");
        wrc(ftp_pkg::RATIO_OFS, 32'h140, 32'h140, "ratio");
        lvl <= {16'd50, 32'h0};
        cyc(8);
        pt(3'h1, 3'h1);
        lvl <= {16'd200, 32'h0};
        cyc(8);
        pt(3'h0, 3'h0);
        wr(ftp_pkg::CTRL_OFS, 32'h5);
        wr(ftp_pkg::RATIO_OFS, 32'he0);
        lvl <= {16'd0, 16'd200, 16'd0};
        cyc(8);
        pt(3'h2, 3'h2);
        `CHK("bf off", 1'b0, bf_start)
        wrap_up();
    end
endmodule

`default_nettype wire
